// ==== mnx_exec.sv ====
// decode and execute of file multiply, file negate and no-operation
// Functional notes
// - multiply word: top seven bits 0000001, then access bit, 8-bit address
// - multiply forms unsigned product of accumulator and file operand
// - product high byte and low byte registers take the 16-bit product
// - multiply leaves accumulator and file register untouched
// - multiply changes no status flag, even on zero product
// - access bit 0 selects access bank, 1 uses bank select register
// - extended set, access bit 0, address up to 95: indexed literal offset
// - negate word: top seven bits 0110110; result is inverted operand plus one
// - negate writes back, updates negative, overflow, carry, digit carry, zero
module mnx_exec (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic I_INSTR_VALID,
    input wire logic [15:0] I_INSTR,
    input wire logic I_EXT_SET_EN,
    input wire logic [7:0] I_BANK_SELECT_REGISTER,
    input wire logic [7:0] I_ACC,
    input wire logic [7:0] I_FILE_RDATA,
    input wire logic [4:0] I_STATUS,
    output logic [7:0] O_FILE_ADDR,
    output mnx_pkg::mnx_bank_t O_FILE_BANK,
    output logic [7:0] O_FILE_BANK_SEL,
    output mnx_pkg::mnx_fwr_t O_FILE_WR,
    output logic [7:0] O_PRODUCT_HIGH_BYTE,
    output logic [7:0] O_PRODUCT_LOW_BYTE,
    output logic O_PROD_WE,
    output logic [4:0] O_STATUS,
    output logic O_STATUS_WE,
    output logic O_DONE,
    output logic O_NOP,
    output logic O_ILLEGAL
);
    import mnx_pkg::*;

    typedef enum logic [1:0] {
        MNX_ST_DECODE,
        MNX_ST_READ,
        MNX_ST_PROCESS,
        MNX_ST_WRITE
    } mnx_phase_t;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic mnx_op_t decode_op(input logic [15:0] w);
        if (w[15:9] == OPC_MUL) begin
            decode_op = MNX_OP_MUL;
        end else if (w[15:9] == OPC_NEG) begin
            decode_op = MNX_OP_NEG;
        end else begin
            decode_op = MNX_OP_NONE;
        end
    endfunction

    function automatic logic is_nop(input logic [15:0] w);
        is_nop = (w == NOP_WORD) || (w[15:12] == OPC_NOP_HI);
    endfunction

    function automatic mnx_bank_t pick_bank(input logic a, input logic ext, input logic [7:0] f);
        if (a) begin
            pick_bank = MNX_BANK_GENERAL;
        end else if (ext && (f <= ILO_LIMIT)) begin
            pick_bank = MNX_BANK_INDEXED;
        end else begin
            pick_bank = MNX_BANK_ACCESS;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    mnx_phase_t phase_reg, phase_next;
    mnx_op_t op_reg, op_next;
    logic [7:0] addr_reg, addr_next;
    mnx_bank_t bank_reg, bank_next;
    logic [7:0] bsel_reg, bsel_next;
    logic [7:0] opnd_reg, opnd_next;
    logic [7:0] acc_reg, acc_next;
    logic [15:0] prod_reg, prod_next;
    logic [7:0] neg_reg, neg_next;
    logic [4:0] flags_reg, flags_next;
    logic [7:0] ph_reg, ph_next;
    logic [7:0] pl_reg, pl_next;
    logic pwe_reg, pwe_next;
    mnx_fwr_t fwr_reg, fwr_next;
    logic [4:0] st_reg, st_next;
    logic swe_reg, swe_next;
    logic done_reg, done_next;
    logic nop_reg, nop_next;
    logic ill_reg, ill_next;
    logic [8:0] neg_sum;
    logic [4:0] neg_lo;

    always_comb begin
        phase_next = phase_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        bank_next = bank_reg;
        bsel_next = bsel_reg;
        opnd_next = opnd_reg;
        acc_next = acc_reg;
        prod_next = prod_reg;
        neg_next = neg_reg;
        flags_next = flags_reg;
        ph_next = ph_reg;
        pl_next = pl_reg;
        pwe_next = 1'b0;
        fwr_next = fwr_reg;
        fwr_next.we = 1'b0;
        st_next = st_reg;
        swe_next = 1'b0;
        done_next = 1'b0;
        nop_next = 1'b0;
        ill_next = 1'b0;
        neg_sum = {1'b0, ~opnd_reg} + 9'h001;
        neg_lo = {1'b0, ~opnd_reg[3:0]} + 5'h01;
        unique case (phase_reg)
            MNX_ST_DECODE: begin
                if (I_INSTR_VALID) begin
                    op_next = decode_op(I_INSTR);
                    addr_next = I_INSTR[7:0];
                    bank_next = pick_bank(I_INSTR[8], I_EXT_SET_EN, I_INSTR[7:0]);
                    bsel_next = I_BANK_SELECT_REGISTER;
                    ill_next = (decode_op(I_INSTR) == MNX_OP_NONE) && !is_nop(I_INSTR);
                    phase_next = MNX_ST_READ;
                end
            end
            MNX_ST_READ: begin
                opnd_next = I_FILE_RDATA;
                acc_next = I_ACC;
                flags_next = I_STATUS;
                phase_next = MNX_ST_PROCESS;
            end
            MNX_ST_PROCESS: begin
                prod_next = 16'(acc_reg) * 16'(opnd_reg);
                neg_next = neg_sum[7:0];
                flags_next[FLAG_C] = neg_sum[8];
                flags_next[FLAG_DIGIT_CARRY] = neg_lo[4];
                flags_next[FLAG_Z] = (neg_sum[7:0] == BYTE_RST);
                flags_next[FLAG_OVERFLOW] = (opnd_reg == 8'h80);
                flags_next[FLAG_N] = neg_sum[7];
                phase_next = MNX_ST_WRITE;
            end
            MNX_ST_WRITE: begin
                done_next = 1'b1;
                nop_next = (op_reg == MNX_OP_NONE);
                if (op_reg == MNX_OP_MUL) begin
                    ph_next = prod_reg[15:8];
                    pl_next = prod_reg[7:0];
                    pwe_next = 1'b1;
                end else if (op_reg == MNX_OP_NEG) begin
                    fwr_next = '{we: 1'b1, bank: bank_reg, bank_sel: bsel_reg, addr: addr_reg, data: neg_reg};
                    st_next = flags_reg;
                    swe_next = 1'b1;
                end
                phase_next = MNX_ST_DECODE;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            phase_reg <= MNX_ST_DECODE;
            op_reg <= MNX_OP_NONE;
            addr_reg <= BYTE_RST;
            bank_reg <= MNX_BANK_ACCESS;
            bsel_reg <= BYTE_RST;
            opnd_reg <= BYTE_RST;
            acc_reg <= BYTE_RST;
            prod_reg <= 16'h0000;
            neg_reg <= BYTE_RST;
            flags_reg <= FLAG_RST;
            ph_reg <= BYTE_RST;
            pl_reg <= BYTE_RST;
            pwe_reg <= 1'b0;
            fwr_reg <= '{we: 1'b0, bank: MNX_BANK_ACCESS, bank_sel: BYTE_RST, addr: BYTE_RST, data: BYTE_RST};
            st_reg <= FLAG_RST;
            swe_reg <= 1'b0;
            done_reg <= 1'b0;
            nop_reg <= 1'b0;
            ill_reg <= 1'b0;
        end else if (I_CE) begin
            phase_reg <= phase_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            bank_reg <= bank_next;
            bsel_reg <= bsel_next;
            opnd_reg <= opnd_next;
            acc_reg <= acc_next;
            prod_reg <= prod_next;
            neg_reg <= neg_next;
            flags_reg <= flags_next;
            ph_reg <= ph_next;
            pl_reg <= pl_next;
            pwe_reg <= pwe_next;
            fwr_reg <= fwr_next;
            st_reg <= st_next;
            swe_reg <= swe_next;
            done_reg <= done_next;
            nop_reg <= nop_next;
            ill_reg <= ill_next;
        end
    end

    assign O_FILE_ADDR = addr_reg;
    assign O_FILE_BANK = bank_reg;
    assign O_FILE_BANK_SEL = bsel_reg;
    assign O_FILE_WR = fwr_reg;
    assign O_PRODUCT_HIGH_BYTE = ph_reg;
    assign O_PRODUCT_LOW_BYTE = pl_reg;
    assign O_PROD_WE = pwe_reg;
    assign O_STATUS = st_reg;
    assign O_STATUS_WE = swe_reg;
    assign O_DONE = done_reg;
    assign O_NOP = nop_reg;
    assign O_ILLEGAL = ill_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_mul_issue;
        phase_reg == MNX_ST_DECODE && I_INSTR_VALID && I_CE && I_INSTR[15:9] == OPC_MUL;
    endsequence

    sequence s_neg_issue;
        phase_reg == MNX_ST_DECODE && I_INSTR_VALID && I_CE && I_INSTR[15:9] == OPC_NEG;
    endsequence

    AST_MUL_DONE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        s_mul_issue ##1 I_CE [*3] |=> O_PROD_WE && O_DONE) else $error("multiply did not write product");
    AST_MUL_PROD: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_PROD_WE |-> {O_PRODUCT_HIGH_BYTE, O_PRODUCT_LOW_BYTE} == 16'(acc_reg) * 16'(opnd_reg))
        else $error("bad product");
    AST_PROD_SPLIT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_PROD_WE |-> O_PRODUCT_HIGH_BYTE == 8'((16'(acc_reg) * 16'(opnd_reg)) >> 8)
        && O_PRODUCT_LOW_BYTE == 8'(acc_reg * opnd_reg))
        else $error("product bytes swapped");
    AST_MUL_NO_FILE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_PROD_WE |-> !O_FILE_WR.we) else $error("multiply wrote file");
    AST_MUL_NO_FLAGS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_PROD_WE |-> !O_STATUS_WE) else $error("multiply wrote status");
    AST_BANK_GENERAL: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        s_neg_issue and I_INSTR[8] |=> O_FILE_BANK == MNX_BANK_GENERAL) else $error("bank select ignored");
    AST_BANK_ILO: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        s_mul_issue and !I_INSTR[8] && I_EXT_SET_EN && I_INSTR[7:0] <= ILO_LIMIT
        |=> O_FILE_BANK == MNX_BANK_INDEXED) else $error("indexed mode missed");
    AST_NEG_VALUE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_FILE_WR.we |-> O_FILE_WR.data == 8'(~opnd_reg + 8'h01)) else $error("bad negate");
    AST_NEG_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_STATUS_WE |-> O_STATUS[FLAG_Z] == (O_FILE_WR.data == BYTE_RST) && O_FILE_WR.we)
        else $error("zero flag wrong");
    AST_CYCLE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        $rose(O_DONE) |-> $past(phase_reg) == MNX_ST_WRITE) else $error("done outside write phase");
    AST_NOP: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
        O_NOP |-> !O_PROD_WE && !O_STATUS_WE && !O_FILE_WR.we) else $error("nop changed state");
endmodule

// ==== mnx_exec_tb.sv ====
// self-checking bench for the multiply/negate/nop execute block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mnx_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mnx_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b0;
    logic instr_valid = 1'b0;
    logic ext_en = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [7:0] bsel_in = 8'h00;
    logic [7:0] acc = 8'h00;
    logic [7:0] frd = 8'h00;
    logic [4:0] status_in = 5'h00;
    logic [7:0] file_addr, bank_sel, prod_hi, prod_lo;
    logic [4:0] status_out;
    logic prod_we, status_we, done, no_operation_instruction, illegal;
    mnx_bank_t file_bank;
    mnx_fwr_t file_wr;
    logic [15:0] prod_m = 16'h0000;
    logic [15:0] w;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 28027;
    localparam logic [7:0] NEGV [6] = '{8'h00, 8'h80, 8'h01, 8'hff, 8'h10, 8'h0f};
    localparam logic [15:0] NOPW [6] = '{16'h0000, 16'hf000, 16'hfabc, 16'hffff, 16'h0001, 16'h1234};

    always #25 clk_sys = ~clk_sys;

    mnx_exec dut_u (
        .I_CLK_SYS(clk_sys), .I_RST_B(rst_b), .I_CE(ce), .I_INSTR_VALID(instr_valid), .I_INSTR(instr),
        .I_EXT_SET_EN(ext_en), .I_BANK_SELECT_REGISTER(bsel_in), .I_ACC(acc), .I_FILE_RDATA(frd),
        .I_STATUS(status_in), .O_FILE_ADDR(file_addr), .O_FILE_BANK(file_bank), .O_FILE_BANK_SEL(bank_sel),
        .O_FILE_WR(file_wr), .O_PRODUCT_HIGH_BYTE(prod_hi), .O_PRODUCT_LOW_BYTE(prod_lo), .O_PROD_WE(prod_we),
        .O_STATUS(status_out), .O_STATUS_WE(status_we), .O_DONE(done), .O_NOP(no_operation_instruction), .O_ILLEGAL(illegal)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one instruction: operands valid through the read phase, garbage afterwards
    task automatic run(input logic [15:0] wd, input logic [7:0] a, input logic [7:0] f, input logic e,
                       input logic rce);
        int n;
        logic [7:0] b, r;
        logic [4:0] st;
        logic is_mul, is_neg, ill, ill_seen;
        mnx_bank_t bk;
        n = 0;
        b = 8'($random(seed));
        is_mul = (wd[15:9] == OPC_MUL);
        is_neg = (wd[15:9] == OPC_NEG);
        ill = !is_mul && !is_neg && wd != NOP_WORD && wd[15:12] != OPC_NOP_HI;
        bk = wd[8] ? MNX_BANK_GENERAL : ((e && wd[7:0] <= ILO_LIMIT) ? MNX_BANK_INDEXED : MNX_BANK_ACCESS);
        r = ~f + 8'h01;
        st = {r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
        @(posedge clk_sys);
        ce <= 1'b1;
        instr_valid <= 1'b1;
        instr <= wd;
        acc <= a;
        frd <= f;
        ext_en <= e;
        bsel_in <= b;
        status_in <= 5'($random(seed));
        @(posedge clk_sys);
        instr <= ~wd;
        ext_en <= ~e;
        bsel_in <= ~b;
        ce <= rce ? 1'($random(seed)) : 1'b1;
        #1;
        ill_seen = illegal;
        // done is launched by the third enabled edge after the take edge
        for (int k = 0; k < 40 && n < 3; k++) begin
            @(posedge clk_sys);
            if (ce) n++;
            instr_valid <= 1'b0;
            ce <= rce ? 1'($random(seed)) : 1'b1;
            if (n > 0) begin
                acc <= acc ^ 8'hff;
                frd <= frd ^ 8'hff;
                status_in <= status_in ^ 5'h1f;
            end
            #1;
            ill_seen |= illegal;
            if (n < 3) `CHK(done, 1'b0)
        end
        if (n < 3) begin
            fail_count++;
            $display("[ERR] %0t no completion", $time);
            close_out();
        end
        if (is_mul) prod_m = 16'(a) * 16'(f);
        `CHK(done, 1'b1)
        `CHK(no_operation_instruction, !(is_mul || is_neg))
        `CHK(ill_seen, ill)
        `CHK(prod_we, is_mul)
        `CHK({prod_hi, prod_lo}, prod_m)
        `CHK(status_we, is_neg)
        `CHK(file_wr.we, is_neg)
        if (is_mul || is_neg) begin
            `CHK(file_addr, wd[7:0])
            `CHK(file_bank, bk)
            if (wd[8]) `CHK(bank_sel, b)
        end
        if (is_neg) begin
            `CHK(file_wr.data, r)
            `CHK(file_wr.addr, wd[7:0])
            `CHK(file_wr.bank, bk)
            if (wd[8]) `CHK(file_wr.bank_sel, b)
            `CHK(status_out, st)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        `CHK(done, 1'b0)
        `CHK({prod_hi, prod_lo}, 16'h0000)
        `CHK(file_wr, '0)
        run(16'h0320, 8'hc4, 8'hb5, 1'b0, 1'b0);
        run(16'h6c40, 8'h5a, 8'h3a, 1'b0, 1'b0);
        $display("test examples done");
        for (int i = 0; i < 6; i++) begin
            run({OPC_NEG, 1'(i), 8'h5e + 8'(i)}, 8'($random(seed)), NEGV[i], i < 4, 1'b0);
            run({OPC_MUL, ~1'(i), 8'h5e + 8'(i)}, 8'($random(seed)), NEGV[i], i < 4, 1'b0);
        end
        $display("test boundaries done");
        for (int i = 0; i < 6; i++) begin
            run(NOPW[i], 8'($random(seed)), 8'($random(seed)), 1'($random(seed)), 1'b1);
        end
        $display("test no-operation done");
        for (int k = 0; k < 60; k++) begin
            w = 16'($random(seed));
            if (k % 3 == 0) w[15:9] = OPC_MUL;
            if (k % 3 == 1) w[15:9] = OPC_NEG;
            run(w, 8'($random(seed)), 8'($random(seed)), 1'($random(seed)), 1'b1);
        end
        $display("test random done");
        close_out();
    end
endmodule

// ==== mnx_pkg.sv ====
// package for the multiply/negate/nop execute block
package mnx_pkg;
    localparam logic [6:0] OPC_MUL = 7'h01;
    localparam logic [6:0] OPC_NEG = 7'h36;
    localparam logic [3:0] OPC_NOP_HI = 4'hf;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [7:0] ILO_LIMIT = 8'h5f;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] FLAG_RST = 5'h00;
    localparam int FLAG_C = 0;
    localparam int FLAG_DIGIT_CARRY = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVERFLOW = 3;
    localparam int FLAG_N = 4;

    typedef enum logic [1:0] {
        MNX_OP_NONE,
        MNX_OP_MUL,
        MNX_OP_NEG
    } mnx_op_t;

    typedef enum logic [1:0] {
        MNX_BANK_ACCESS,
        MNX_BANK_GENERAL,
        MNX_BANK_INDEXED
    } mnx_bank_t;

    typedef struct packed {
        logic we;
        mnx_bank_t bank;
        logic [7:0] bank_sel;
        logic [7:0] addr;
        logic [7:0] data;
    } mnx_fwr_t;
endpackage
